// [design/atf_adc_timing.v]
// acquisition timing, sample load, repeat tally, filter output and result registers
// Overview of operation
// - 13-bit sample-share time sets acquisition length
// - both settings zero skips acquisition entirely
// - zero setting, nonzero setup gives 8192 cycles
// - load code n adds n picofarads
// - threshold count decides triggers before check
// - tally counts triggers in average, burst and low-pass modes, compared with threshold
// - filter output is running sum shifted right
// - low-pass mode loads filter with lowpass result
// - left justify puts bits 11:4 high byte
// - left justify puts bits 3:0 low nibble-high
// - sample-share high byte bits 7:5 read zero
// - right justify puts bits 11:8, 7:0
// - clock select picks divided oscillator or rc
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "atf_defines.vh"
module atf_adc_timing (
  input  wire        clk,
  input  wire        reset_n,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // timing sources
  input  wire        sys_div_tick,
  input  wire        dedicated_rc_oscillator,
  // computation side
  input  wire        conv_trigger,
  input  wire [2:0]  computation_mode,
  input  wire [17:0] running_sum,
  input  wire [2:0]  shift_amount,
  input  wire [15:0] lowpass_computation,
  input  wire        filter_update,
  input  wire        conv_valid,
  input  wire [11:0] conv_value_in,
  // outputs to the analogue side
  output reg  [30:0] extra_sampling_load_q,
  output reg         acq_active_q,
  output reg         convert_start_q,
  output reg         threshold_check_q
);
  // software-held settings; 13-bit fields are written a byte at a time,
  // so a phase started between the two writes runs with a mixed value;
  // software should update both bytes while no conversion is pending
  reg [12:0] sample_share_setting_q; // acquisition length
  reg [12:0] charge_setup_duration_q; // precharge length
  reg [4:0]  extra_sampling_load_code_q; // extra cap code
  reg [7:0]  trigger_threshold_count_q; // repeat threshold
  reg [7:0]  trigger_tally_count_q; // repeat tally
  reg [15:0] filter_output_q; // signed filter output
  reg [11:0] conversion_value_q; // last result
  reg        justify_select_q; // 0 left, 1 right
  reg        rc_select_q; // 0 divided osc, 1 rc
  reg        conv_req_q; // software conversion request pulse

  // phase machine, one-hot; the code is also the status readback, so
  // software sees idle, setup, acquire or convert as a single set bit
  // a trigger that arrives outside idle is dropped, not queued: the
  // analogue side cannot take a second sample in the middle of a cycle
  // the default branch recovers an illegal code to idle with the
  // acquisition switch open
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_PRE  = 4'b0010;
  localparam [3:0] ST_ACQ  = 4'b0100;
  localparam [3:0] ST_CONV = 4'b1000;
  reg [3:0] state_q;

  reg        rc_meta_q; // first stage of rc sampler, read only by rc_sync_q
  reg        rc_sync_q;
  reg        rc_prev_q;
  wire       rc_tick;
  wire       sel_tick;
  reg        cnt_load;
  reg [13:0] cnt_value;
  wire       cnt_busy;
  wire       cnt_done;
  wire       bus_req;
  wire       wr_hit;
  wire       avg_mode;
  wire [17:0] shifted_sum;
  wire       start;
  reg [7:0]  rd_byte;

  // rc oscillator is asynchronous; two flops then an edge detect on the second
  // the edge is seen three clocks late, which moves the phase but never
  // shortens it; the rc source must stay well below half the clock rate
  // or edges will be lost and the phase will stretch
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rc_meta_q <= 1'b0;
      rc_sync_q <= 1'b0;
      rc_prev_q <= 1'b0;
    end else begin
      rc_meta_q <= dedicated_rc_oscillator;
      rc_sync_q <= rc_meta_q;
      rc_prev_q <= rc_sync_q;
    end
  end
  assign rc_tick  = rc_sync_q & ~rc_prev_q;
  assign sel_tick = rc_select_q ? rc_tick : sys_div_tick;

  // single-cycle bus answer: waitrequest drops the cycle after a request
  // a request is taken only while waitrequest is high, so a held strobe is
  // answered once; writes land at the edge that sees waitrequest low
  // the tally counts only in the modes that compare against the threshold
  // a software conversion request starts a cycle just like a pin trigger
  assign bus_req = (avs_read | avs_write) & avs_waitrequest;
  assign wr_hit  = avs_write & ~avs_waitrequest;
  assign avg_mode = (computation_mode == `ATF_MODE_AVG) ||
                    (computation_mode == `ATF_MODE_BURST) ||
                    (computation_mode == `ATF_MODE_LPF);
  assign start = conv_trigger | conv_req_q;
  assign shifted_sum = $signed(running_sum) >>> shift_amount;

  // shared down counter serves both precharge and acquisition phases
  // the two phases never overlap, so one counter saves a second 14-bit
  // register; the extra top bit holds the 8192 default, one past the field
  atf_tick_counter u_counter (
    .clk        (clk),
    .reset_n    (reset_n),
    .load       (cnt_load),
    .load_value (cnt_value),
    .tick       (sel_tick),
    .busy_q     (cnt_busy),
    .done_q     (cnt_done)
  );

  // decide phase loads; acquisition value with its zero-case exceptions
  // a zero precharge skips straight to acquisition; a zero acquisition
  // with no precharge leaves the counter unloaded and the phase out
  always @* begin
    cnt_load  = 1'b0;
    cnt_value = 14'h0000;
    case (state_q)
      ST_IDLE: begin
        if (start && charge_setup_duration_q != 13'h0000) begin
          cnt_load  = 1'b1;
          cnt_value = {1'b0, charge_setup_duration_q};
        end else if (start && sample_share_setting_q != 13'h0000) begin
          cnt_load  = 1'b1;
          cnt_value = {1'b0, sample_share_setting_q};
        end
      end
      ST_PRE: begin
        if (cnt_done) begin
          cnt_load  = 1'b1;
          // zero setting after a precharge means the long default
          cnt_value = (sample_share_setting_q == 13'h0000) ?
                      `ATF_ACQ_DEFAULT : {1'b0, sample_share_setting_q};
        end
      end
      default: begin
        cnt_load  = 1'b0;
        cnt_value = 14'h0000;
      end
    endcase
  end

  // precharge, then acquisition, then a one-cycle convert start
  // acq_active_q rises with the counter load and falls the cycle after the
  // last tick, so the analogue switch stays closed for the whole count
  // the convert start follows one cycle later, giving the sample a clock
  // to settle before conversion begins
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q         <= ST_IDLE;
      acq_active_q    <= 1'b0;
      convert_start_q <= 1'b0;
    end else begin
      convert_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            if (charge_setup_duration_q != 13'h0000) begin
              state_q <= ST_PRE;
            end else if (sample_share_setting_q != 13'h0000) begin
              state_q      <= ST_ACQ;
              acq_active_q <= 1'b1;
            end else begin
              state_q <= ST_CONV;
            end
          end
        end
        ST_PRE: begin
          if (cnt_done) begin
            state_q      <= ST_ACQ;
            acq_active_q <= 1'b1;
          end
        end
        ST_ACQ: begin
          if (cnt_done) begin
            state_q      <= ST_CONV;
            acq_active_q <= 1'b0;
          end
        end
        ST_CONV: begin
          convert_start_q <= 1'b1;
          state_q         <= ST_IDLE;
        end
        default: begin
          state_q      <= ST_IDLE;
          acq_active_q <= 1'b0;
        end
      endcase
    end
  end

  // thermometer decode of extra capacitance: code n enables n 1 pF units
  // each output bit switches one unit, so any code turns on the lowest n;
  // a change of code therefore moves only the bits between old and new
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extra_sampling_load_q <= 31'h00000000;
    end else begin
      extra_sampling_load_q <= ~(31'h7FFFFFFF << extra_sampling_load_code_q);
    end
  end

  // register writes, tally, filter and result capture
  // hardware events beat software writes in the same cycle: a trigger
  // steps the tally and a fresh conversion replaces the result, since
  // losing a sample would be worse than losing a stale write
  // the threshold compare uses the stepped value so the check lines up
  // with the trigger that reaches the count; the tally wraps past 255
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_share_setting_q     <= 13'h0000;
      charge_setup_duration_q    <= 13'h0000;
      extra_sampling_load_code_q <= 5'h00;
      trigger_threshold_count_q  <= `ATF_RST_BYTE;
      trigger_tally_count_q      <= `ATF_RST_BYTE;
      filter_output_q            <= 16'h0000;
      conversion_value_q         <= 12'h000;
      justify_select_q           <= 1'b0;
      rc_select_q                <= 1'b0;
      conv_req_q                 <= 1'b0;
      threshold_check_q          <= 1'b0;
    end else begin
      conv_req_q        <= 1'b0;
      threshold_check_q <= 1'b0;
      // hardware tally step; a same-cycle software write is overridden below
      if (conv_trigger && avg_mode) begin
        trigger_tally_count_q <= trigger_tally_count_q + 8'h01;
        if (trigger_tally_count_q + 8'h01 >= trigger_threshold_count_q) begin
          threshold_check_q <= 1'b1;
        end
      end else if (wr_hit && avs_address == `ATF_OFS_CNT) begin
        trigger_tally_count_q <= avs_writedata[7:0];
      end
      // the running sum is 18 bits; shifts below two lose its top bits,
      // so software must pick a shift that fits the sum into 16 bits
      if (filter_update) begin
        if (computation_mode == `ATF_MODE_LPF) begin
          filter_output_q <= lowpass_computation;
        end else begin
          filter_output_q <= shifted_sum[15:0];
        end
      end
      // result registers are writable but a fresh conversion wins
      if (conv_valid) begin
        conversion_value_q <= conv_value_in;
      end else if (wr_hit && avs_address == `ATF_OFS_RES_HIGH) begin
        if (justify_select_q) begin
          conversion_value_q[11:8] <= avs_writedata[3:0];
        end else begin
          conversion_value_q[11:4] <= avs_writedata[7:0];
        end
      end else if (wr_hit && avs_address == `ATF_OFS_RES_LOW) begin
        if (justify_select_q) begin
          conversion_value_q[7:0] <= avs_writedata[7:0];
        end else begin
          conversion_value_q[3:0] <= avs_writedata[7:4];
        end
      end
      if (wr_hit) begin
        case (avs_address)
          `ATF_OFS_ACQ_LOW:  sample_share_setting_q[7:0]  <= avs_writedata[7:0];
          `ATF_OFS_ACQ_HIGH: sample_share_setting_q[12:8] <= avs_writedata[4:0];
          `ATF_OFS_CAP:      extra_sampling_load_code_q    <= avs_writedata[4:0];
          `ATF_OFS_RPT:      trigger_threshold_count_q     <= avs_writedata[7:0];
          `ATF_OFS_PRE_LOW:  charge_setup_duration_q[7:0]  <= avs_writedata[7:0];
          `ATF_OFS_PRE_HIGH: charge_setup_duration_q[12:8] <= avs_writedata[4:0];
          `ATF_OFS_CTRL: begin
            justify_select_q <= avs_writedata[`ATF_CTRL_JUSTIFY];
            rc_select_q      <= avs_writedata[`ATF_CTRL_RCSEL];
            conv_req_q       <= avs_writedata[`ATF_CTRL_CONV_REQ];
          end
          default: begin
            conv_req_q <= 1'b0; // unmapped or read-only: write ignored; tally and result offsets land here too but are written above
          end
        endcase
      end
    end
  end

  // read mux, result bytes formatted by justification
  // unimplemented and reserved bits read zero; the result bytes are
  // packed on the fly, so changing justification reformats an old result
  always @* begin
    case (avs_address)
      `ATF_OFS_ACQ_LOW:  rd_byte = sample_share_setting_q[7:0];
      `ATF_OFS_ACQ_HIGH: rd_byte = {3'h0, sample_share_setting_q[12:8]};
      `ATF_OFS_CAP:      rd_byte = {3'h0, extra_sampling_load_code_q};
      `ATF_OFS_RPT:      rd_byte = trigger_threshold_count_q;
      `ATF_OFS_CNT:      rd_byte = trigger_tally_count_q;
      `ATF_OFS_FLT_HIGH: rd_byte = filter_output_q[15:8];
      `ATF_OFS_FLT_LOW:  rd_byte = filter_output_q[7:0];
      `ATF_OFS_RES_HIGH: rd_byte = justify_select_q ?
                                   {4'h0, conversion_value_q[11:8]} :
                                   conversion_value_q[11:4];
      `ATF_OFS_RES_LOW:  rd_byte = justify_select_q ?
                                   conversion_value_q[7:0] :
                                   {conversion_value_q[3:0], 4'h0};
      `ATF_OFS_PRE_LOW:  rd_byte = charge_setup_duration_q[7:0];
      `ATF_OFS_PRE_HIGH: rd_byte = {3'h0, charge_setup_duration_q[12:8]};
      `ATF_OFS_CTRL:     rd_byte = {6'h00, rc_select_q, justify_select_q};
      `ATF_OFS_STATUS:   rd_byte = {4'h0, state_q};
      default:           rd_byte = 8'h00;
    endcase
  end

  // waitrequest high at idle; one wait cycle, then answer with data
  // read data is registered with the answer and then held, so a slow
  // master may still sample it after waitrequest has risen again
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      if (bus_req) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= {24'h000000, rd_byte};
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end
endmodule // atf_adc_timing

// [include/atf_defines.vh]
// register offsets, field layouts, reset values and timing counts for the adc timing block
`ifndef ATF_DEFINES_VH
`define ATF_DEFINES_VH
// register word addresses (one register per word, data in low byte)
`define ATF_OFS_ACQ_LOW    4'h0
`define ATF_OFS_ACQ_HIGH   4'h1
`define ATF_OFS_CAP        4'h2
`define ATF_OFS_RPT        4'h3
`define ATF_OFS_CNT        4'h4
`define ATF_OFS_FLT_HIGH   4'h5
`define ATF_OFS_FLT_LOW    4'h6
`define ATF_OFS_RES_HIGH   4'h7
`define ATF_OFS_RES_LOW    4'h8
`define ATF_OFS_PRE_LOW    4'h9
`define ATF_OFS_PRE_HIGH   4'hA
`define ATF_OFS_CTRL       4'hB
`define ATF_OFS_STATUS     4'hC
// field widths and positions
`define ATF_ACQ_W          13
`define ATF_CAP_W          5
`define ATF_CTRL_JUSTIFY   0
`define ATF_CTRL_RCSEL     1
`define ATF_CTRL_CONV_REQ  2
// reset values
`define ATF_RST_BYTE       8'h00
// acquisition length when the setting is zero but charge setup is nonzero
`define ATF_ACQ_DEFAULT    14'h2000
// computation modes
`define ATF_MODE_BASIC     3'h0
`define ATF_MODE_ACCUM     3'h1
`define ATF_MODE_AVG       3'h2
`define ATF_MODE_BURST     3'h3
`define ATF_MODE_LPF       3'h4
`endif

// [design/atf_tick_counter.v]
// down counter that counts ticks of the selected conversion clock
`timescale 1ns/100ps
module atf_tick_counter (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        load,
  input  wire [13:0] load_value,
  input  wire        tick,
  output reg         busy_q,
  output reg         done_q
);
  reg [13:0] count_q; // cycles still to run

  // load starts a phase; each tick of the chosen clock takes one away
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 14'h0000;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load) begin
        count_q <= load_value;
        busy_q  <= (load_value != 14'h0000);
        done_q  <= (load_value == 14'h0000);
      end else if (busy_q && tick) begin
        count_q <= count_q - 14'h0001;
        if (count_q == 14'h0001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule // atf_tick_counter

// [tb/atf_adc_timing_checker.sv]
// port-level checks on the adc timing block
`timescale 1ns/100ps
module atf_adc_timing_checker (
  input wire        clk,
  input wire        reset_n,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        conv_trigger,
  input wire [2:0]  computation_mode,
  input wire [30:0] extra_sampling_load_q,
  input wire        acq_active_q,
  input wire        convert_start_q,
  input wire        threshold_check_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a taken request, then a one-cycle answer
  sequence req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence ans_s; !avs_waitrequest ##1 avs_waitrequest; endsequence
  // end of acquisition, then the conversion starts
  sequence acq_end_s; $fell(acq_active_q) ##1 convert_start_q; endsequence
  bus_answer_a: assert property (req_s |=> ans_s)
    else $error("bus answer late or too long");
  unused_high_a: assert property (!avs_waitrequest && avs_read && avs_address == 4'h1
    |-> avs_readdata[7:5] == 3'h0) else $error("unused sample time bits not zero");
  upper_zero_a: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  load_thermo_a: assert property (((extra_sampling_load_q + 31'h1) & extra_sampling_load_q) == 0)
    else $error("sample load not a thermometer code");
  conv_after_acq_a: assert property ($fell(acq_active_q) |-> acq_end_s)
    else $error("conversion did not follow acquisition");
  conv_pulse_a: assert property (convert_start_q |=> !convert_start_q)
    else $error("convert start longer than one cycle");
  acq_quiet_a: assert property (acq_active_q |-> !convert_start_q)
    else $error("convert start during acquisition");
  check_cause_a: assert property (threshold_check_q |-> $past(conv_trigger)
    && $past(computation_mode) >= 3'h2 && $past(computation_mode) <= 3'h4)
    else $error("threshold check without counted trigger");
endmodule // atf_adc_timing_checker

bind atf_adc_timing atf_adc_timing_checker chk_u (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .conv_trigger(conv_trigger), .computation_mode(computation_mode),
  .extra_sampling_load_q(extra_sampling_load_q), .acq_active_q(acq_active_q),
  .convert_start_q(convert_start_q), .threshold_check_q(threshold_check_q));

// [tb/test_atf_adc_timing.sv]
// self-checking bench for the adc timing, filter and result registers
`timescale 1ns/100ps
module test_atf_adc_timing;
  reg         clk, reset_n, avs_read, avs_write;  // clock, reset, bus strobes
  reg  [3:0]  avs_address;                        // word index
  reg  [31:0] avs_writedata;                      // only low byte used
  wire [31:0] avs_readdata;                       // read answer
  wire        avs_waitrequest;                    // low one cycle per answer
  reg         sys_div_tick, dedicated_rc_oscillator, conv_trigger, filter_update, conv_valid;
  reg  [2:0]  computation_mode, shift_amount;     // computation controls
  reg  [17:0] running_sum;                        // signed sum
  reg  [15:0] lowpass_computation;                // low-pass result
  reg  [11:0] conv_value_in;                      // raw conversion value
  wire [30:0] extra_sampling_load_q;              // thermometer load
  wire        acq_active_q, convert_start_q, threshold_check_q;
  integer     num_errors, checks_done, i, n, v, s, f, acq_n, tk_n, thr_n;
  integer     mdl [0:15];                         // register model
  integer     wmask [0:15];                       // writable bits per word
  reg  [1:0]  tdiv, rdiv;                         // tick dividers
  reg  [31:0] rd;                                 // last read data

  atf_adc_timing dut_u (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sys_div_tick(sys_div_tick), .dedicated_rc_oscillator(dedicated_rc_oscillator),
    .conv_trigger(conv_trigger), .computation_mode(computation_mode),
    .running_sum(running_sum), .shift_amount(shift_amount),
    .lowpass_computation(lowpass_computation), .filter_update(filter_update),
    .conv_valid(conv_valid), .conv_value_in(conv_value_in),
    .extra_sampling_load_q(extra_sampling_load_q), .acq_active_q(acq_active_q),
    .convert_start_q(convert_start_q), .threshold_check_q(threshold_check_q));

  always #20 clk = ~clk;

  // ticks every 4 cycles; rc period 6 cycles so the two sources tell apart
  always @(posedge clk) begin
    tdiv <= tdiv + 2'd1;
    sys_div_tick <= (tdiv == 2'd0);
    rdiv <= (rdiv == 2'd2) ? 2'd0 : rdiv + 2'd1;
    if (rdiv == 2'd2) dedicated_rc_oscillator <= ~dedicated_rc_oscillator;
    if (threshold_check_q === 1'b1) thr_n <= thr_n + 1;
  end

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // one bus cycle; held until waitrequest is sampled low
  task bus(input wr, input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, d};
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) num_errors = num_errors + 1;
      if (wr) mdl[a] = d & wmask[a];
    end
  endtask

  task rdc(input [3:0] a);
    begin
      bus(1'b0, a, 8'h00);
      chk("register", mdl[a], rd);
    end
  endtask

  // trigger one conversion, count acquisition cycles and ticks in it
  task conv;
    begin
      @(posedge clk);
      conv_trigger <= 1'b1;
      @(posedge clk);
      conv_trigger <= 1'b0;
      acq_n = 0;
      tk_n = 0;
      n = 0;
      while (convert_start_q !== 1'b1 && n < 40000) begin
        @(posedge clk);
        n = n + 1;
        if (acq_active_q === 1'b1) acq_n = acq_n + 1;
        if (acq_active_q === 1'b1 && sys_div_tick === 1'b1) tk_n = tk_n + 1;
      end
      if (n >= 40000) num_errors = num_errors + 1;
    end
  endtask

  task summarize;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask

  // watchdog at 80k cycles: the long 8192-tick case needs about 33k, the rest a few thousand
  initial begin
    #3200000;
    num_errors = num_errors + 1;
    summarize;
  end

  initial begin
    {clk, reset_n, avs_read, avs_write, avs_address, avs_writedata} = 0;
    {sys_div_tick, dedicated_rc_oscillator, conv_trigger, filter_update, conv_valid} = 0;
    {computation_mode, shift_amount, running_sum, lowpass_computation, conv_value_in} = 0;
    {tdiv, rdiv, num_errors, checks_done, thr_n} = 0;
    for (i = 0; i < 16; i = i + 1) begin
      mdl[i] = 0;
      wmask[i] = (i == 1 || i == 2 || i == 10) ? 8'h1F : (i < 5 || i == 9) ? 8'hFF : 0;
    end
    mdl[12] = 8'h01;
    v = $urandom(32'h6d5c);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 0; i < 16; i = i + 1) rdc(i);
    bus(1'b1, 4'h1, 8'hFF);
    bus(1'b1, 4'h3, $urandom);
    bus(1'b1, 4'h5, 8'hAA);
    bus(1'b1, 4'hD, 8'h55);
    for (i = 0; i < 16; i = i + 1) rdc(i);
    for (i = 0; i < 6; i = i + 1) begin
      v = (i == 0) ? 0 : (i == 1) ? 31 : $urandom % 32;
      bus(1'b1, 4'h2, v);
      repeat (2) @(posedge clk);
      chk("sample load", (32'h1 << v) - 1, {1'b0, extra_sampling_load_q});
    end
    bus(1'b1, 4'h1, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      bus(1'b1, 4'h0, 8'h05 - 3 * i);
      bus(1'b1, 4'h1, i);
      conv;
      chk("acq ticks", 5 + 253 * i, tk_n);
    end
    bus(1'b1, 4'hB, 8'h02);
    bus(1'b1, 4'h1, 8'h00);
    bus(1'b1, 4'h0, 8'h05);
    conv;
    chk("rc span", 1, acq_n >= 24 && acq_n <= 38);
    bus(1'b1, 4'hB, 8'h00);
    bus(1'b1, 4'h0, 8'h00);
    conv;
    chk("no acq", 0, acq_n);
    chk("fast conv", 1, n <= 3);
    bus(1'b1, 4'hB, 8'h04);
    n = 0;
    while (convert_start_q !== 1'b1 && n < 50) begin
      @(posedge clk);
      n = n + 1;
    end
    chk("soft start", 1, n <= 4);
    bus(1'b1, 4'h9, 8'h01);
    conv;
    chk("long acq", 8192, tk_n);
    bus(1'b1, 4'h9, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      v = $urandom;
      s = $urandom % 8;
      @(posedge clk);
      computation_mode <= 1 + i % 4;
      running_sum <= v[17:0];
      shift_amount <= s;
      lowpass_computation <= v[31:16];
      filter_update <= 1'b1;
      @(posedge clk);
      filter_update <= 1'b0;
      f = $signed(v[17:0]); // sign-extend the sum before shifting
      f = f >>> s;
      mdl[5] = (i % 4 == 3) ? v[31:24] : (f >> 8) & 255;
      mdl[6] = (i % 4 == 3) ? v[23:16] : f & 255;
      rdc(5);
      rdc(6);
    end
    for (i = 0; i < 2; i = i + 1) begin
      bus(1'b1, 4'hB, i);
      v = $urandom % 4096;
      @(posedge clk);
      conv_value_in <= v;
      conv_valid <= 1'b1;
      @(posedge clk);
      conv_valid <= 1'b0;
      bus(1'b0, 4'h7, 8'h00);
      chk("result high", i ? v >> 8 : v >> 4, rd);
      bus(1'b0, 4'h8, 8'h00);
      chk("result low", i ? v & 255 : (v & 15) << 4, rd);
    end
    bus(1'b1, 4'hB, 8'h00);
    computation_mode <= 3'h2;
    bus(1'b1, 4'h3, 8'h03);
    bus(1'b1, 4'h4, 8'h00);
    s = thr_n;
    repeat (3) conv;
    mdl[4] = 3;
    rdc(4);
    chk("threshold checks", 1, thr_n - s);
    // basic and accumulate hold the tally; burst and low-pass count like average
    for (i = 0; i < 4; i = i + 1) begin
      computation_mode <= i + (i > 1);
      conv;
      mdl[4] = mdl[4] + (i > 1);
      rdc(4);
    end
    summarize;
  end
endmodule // test_atf_adc_timing
